/* File: logic/bplc_pkg.sv */
// Constants and types shared by the BCD preset load control block
package bplc_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 100;
    // One digit-active phase of the free-running scan oscillator
    localparam int DIGIT_PHASE_NS = 400000;
    localparam int DIGIT_CYCLES = DIGIT_PHASE_NS / CLK_PERIOD_NS;
    // Shortest load pulse that must start a full entry sequence
    localparam int LOAD_PULSE_NS = 500;
    localparam int LOAD_PULSE_CYCLES = (LOAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Load completion after release, typical and worst case
    localparam int LOAD_TYP_NS = 1600000;
    localparam int LOAD_MAX_NS = 5000000;
    localparam int LOAD_TYP_CYCLES = LOAD_TYP_NS / CLK_PERIOD_NS;
    localparam int LOAD_MAX_CYCLES = LOAD_MAX_NS / CLK_PERIOD_NS;
    localparam int DIGITS = 4;
    localparam int OSC_W = 16;
    localparam int WATCH_W = 24;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_COMPARE = 8'h08;
    localparam logic [7:0] OFS_PRESET = 8'h0c;
    // Control fields
    localparam int CTRL_CATHODE_BIT = 0;
    localparam int CTRL_EXT_SCAN_BIT = 1;
    // Status fields
    localparam int ST_LOADING_BIT = 0;
    localparam int ST_MATCH_BIT = 1;
    localparam int ST_ZERO_BIT = 2;
    localparam int ST_PHASE_LSB = 4;
    localparam int ST_CNT_LVL_LSB = 8;
    localparam int ST_CMP_LVL_LSB = 10;
    localparam int ST_DISP_LVL_LSB = 12;
    localparam logic CTRL_EXT_SCAN_RST = 1'b0;
    localparam logic [1:0] PHASE_MSD = 2'h3;
    localparam logic [1:0] PHASE_LSD = 2'h0;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {LVL_OPEN, LVL_HIGH, LVL_LOW} bplc_lvl_type;
    typedef enum logic {FSM_NORMAL, FSM_LOAD} bplc_fsm_type;
endpackage

/* File: logic/bplc_top.sv */
// BCD preset load control: load sequencing, port direction, display mode and APB registers
`timescale 1ns/10ps
module bplc_top
    import bplc_pkg::*;
#(
    parameter int DIGIT_CYCLES_P = DIGIT_CYCLES,
    parameter int LOAD_MAX_CYCLES_P = LOAD_MAX_CYCLES,
    parameter bit CATHODE_VARIANT = 1'b0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Three-level selects, each as high and low sense lines
    input wire logic counter_preset_select_hi,
    input wire logic counter_preset_select_lo,
    input wire logic compare_preset_select_hi,
    input wire logic compare_preset_select_lo,
    input wire logic display_mode_select_hi,
    input wire logic display_mode_select_lo,
    // Scan node and counter side
    input wire logic scan_tick_ext,
    input wire logic counter_reset_n,
    input wire logic [15:0] counter_value,
    input wire logic [15:0] latch_value,
    output logic count_inhibit,
    output logic [15:0] counter_preset_value,
    output logic counter_preset_load,
    output logic match_n,
    output logic zero_n,
    output logic result_valid,
    // BCD port and display control
    input wire logic [3:0] bcd_in,
    output logic [3:0] bcd_out,
    output logic bcd_oe,
    output logic [3:0] digit_strobe,
    output logic segment_enable,
    output logic zero_blank_enable
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        bplc_fsm_type fsm;
        logic [1:0] phase;
        logic [OSC_W-1:0] osc_cnt;
        logic ld_cnt;
        logic ld_reg;
        logic cnt_was_high;
        logic cmp_was_high;
        logic [15:0] cmp;
        logic [15:0] preset;
        logic preset_load;
        logic [3:0] bcd_out;
        logic bcd_oe;
        logic [3:0] strobe;
        logic seg_en;
        logic lzb_en;
        logic match_n;
        logic zero_n;
        logic cathode;
        logic ext_scan;
        logic [31:0] prdata;
        logic pslverr;
    } bplc_state_type;

    bplc_state_type st_q;
    bplc_state_type st_d;
    bplc_lvl_type cnt_lvl;
    bplc_lvl_type cmp_lvl;
    bplc_lvl_type disp_lvl;
    logic osc_tick;
    logic scan_tick;
    logic [3:0] bcd_data;
    logic cnt_rise;
    logic cmp_rise;
    logic [31:0] rd_word;
    logic rd_hit;

    // Resolve a three-level select from its sense lines
    function automatic bplc_lvl_type resolve(input logic hi, input logic lo);
        bplc_lvl_type r;
        r = LVL_OPEN;
        if (hi && !lo) begin
            r = LVL_HIGH;
        end else if (lo && !hi) begin
            r = LVL_LOW;
        end
        return r;
    endfunction

    // ****************************************
    // Input decode
    // ****************************************
    // Select resolution
    assign cnt_lvl = resolve(counter_preset_select_hi, counter_preset_select_lo);
    assign cmp_lvl = resolve(compare_preset_select_hi, compare_preset_select_lo);
    assign disp_lvl = resolve(display_mode_select_hi, display_mode_select_lo);
    // Rising edges into the high state
    assign cnt_rise = (cnt_lvl == LVL_HIGH) && !st_q.cnt_was_high;
    assign cmp_rise = (cmp_lvl == LVL_HIGH) && !st_q.cmp_was_high;
    // Free-running oscillator and the selected scan source
    assign osc_tick = (st_q.osc_cnt == OSC_W'(DIGIT_CYCLES_P - 1));
    assign scan_tick = st_q.ext_scan ? scan_tick_ext : osc_tick;
    // Port digit, polarity and forced zero under counter reset
    assign bcd_data = !counter_reset_n ? 4'h0 : (st_q.cathode ? ~bcd_in : bcd_in);

    // Register read mux
    always_comb begin
        rd_word = 32'h0;
        rd_hit = 1'b1;
        case (paddr)
            OFS_CTRL: begin
                rd_word[CTRL_CATHODE_BIT] = st_q.cathode;
                rd_word[CTRL_EXT_SCAN_BIT] = st_q.ext_scan;
            end
            OFS_STATUS: begin
                rd_word[ST_LOADING_BIT] = (st_q.fsm == FSM_LOAD);
                rd_word[ST_MATCH_BIT] = !st_q.match_n;
                rd_word[ST_ZERO_BIT] = !st_q.zero_n;
                rd_word[ST_PHASE_LSB +: 2] = st_q.phase;
                rd_word[ST_CNT_LVL_LSB +: 2] = cnt_lvl;
                rd_word[ST_CMP_LVL_LSB +: 2] = cmp_lvl;
                rd_word[ST_DISP_LVL_LSB +: 2] = disp_lvl;
            end
            OFS_COMPARE: begin
                rd_word[15:0] = st_q.cmp;
            end
            OFS_PRESET: begin
                rd_word[15:0] = st_q.preset;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_d = st_q;
        st_d.preset_load = 1'b0;
        st_d.cnt_was_high = (cnt_lvl == LVL_HIGH);
        st_d.cmp_was_high = (cmp_lvl == LVL_HIGH);
        case (st_q.fsm)
            FSM_NORMAL: begin
                if (cnt_rise || cmp_rise) begin
                    // Restart scan at MSD on internal oscillator
                    st_d.fsm = FSM_LOAD;
                    st_d.osc_cnt = '0;
                    st_d.phase = PHASE_MSD;
                    st_d.ld_cnt = cnt_rise;
                    st_d.ld_reg = cmp_rise;
                end else if (cmp_lvl == LVL_LOW) begin
                    // Display off: oscillator held, digit parked at MSD
                    st_d.osc_cnt = '0;
                    st_d.phase = PHASE_MSD;
                end else begin
                    st_d.osc_cnt = osc_tick ? '0 : st_q.osc_cnt + OSC_W'(1);
                    if (scan_tick) begin
                        st_d.phase = st_q.phase - 2'h1;
                    end
                end
            end
            FSM_LOAD: begin
                st_d.ld_cnt = st_q.ld_cnt | cnt_rise;
                st_d.ld_reg = st_q.ld_reg | cmp_rise;
                st_d.osc_cnt = osc_tick ? '0 : st_q.osc_cnt + OSC_W'(1);
                if (osc_tick) begin
                    // Digit taken at the trailing edge of its phase
                    if (st_q.ld_cnt) begin
                        st_d.preset[{st_q.phase, 2'b00} +: 4] = bcd_data;
                        st_d.preset_load = 1'b1;
                    end
                    if (st_q.ld_reg) begin
                        st_d.cmp[{st_q.phase, 2'b00} +: 4] = bcd_data;
                    end
                    st_d.phase = st_q.phase - 2'h1;
                    if (st_q.phase == PHASE_LSD) begin
                        // End of pass: resample both selects
                        st_d.ld_cnt = (cnt_lvl == LVL_HIGH);
                        st_d.ld_reg = (cmp_lvl == LVL_HIGH);
                        if ((cnt_lvl != LVL_HIGH) && (cmp_lvl != LVL_HIGH)) begin
                            st_d.fsm = FSM_NORMAL;
                        end
                    end
                end
            end
            default: begin
                st_d.fsm = FSM_NORMAL;
            end
        endcase
        // Port direction: drive only when idle with both selects open
        st_d.bcd_oe = (st_d.fsm == FSM_NORMAL) && (cnt_lvl == LVL_OPEN) && (cmp_lvl == LVL_OPEN);
        st_d.bcd_out = latch_value[{st_d.phase, 2'b00} +: 4];
        // Display drivers
        st_d.strobe = (cmp_lvl == LVL_LOW) ? 4'h0 : (4'h1 << st_d.phase);
        st_d.seg_en = (cmp_lvl != LVL_LOW) && (disp_lvl != LVL_HIGH);
        st_d.lzb_en = (disp_lvl != LVL_LOW);
        // XOR compare and zero detect keep running in display off
        st_d.match_n = |(st_q.cmp ^ counter_value);
        st_d.zero_n = |counter_value;
        // APB: answer prepared in setup, presented in access
        if (psel && !penable) begin
            st_d.prdata = rd_word;
            st_d.pslverr = !rd_hit;
        end
        if (psel && penable && pwrite && (paddr == OFS_CTRL)) begin
            st_d.cathode = pwdata[CTRL_CATHODE_BIT];
            st_d.ext_scan = pwdata[CTRL_EXT_SCAN_BIT];
        end
    end

    // State register; compare register has no clear but power-on
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '{fsm: FSM_NORMAL, phase: PHASE_MSD, cathode: CATHODE_VARIANT, ext_scan: CTRL_EXT_SCAN_RST,
                      match_n: 1'b1, zero_n: 1'b1, default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata = st_q.prdata;
    assign pready = 1'b1;
    assign pslverr = st_q.pslverr;
    assign count_inhibit = (cnt_lvl == LVL_HIGH) || ((st_q.fsm == FSM_LOAD) && st_q.ld_cnt);
    assign counter_preset_value = st_q.preset;
    assign counter_preset_load = st_q.preset_load;
    assign match_n = st_q.match_n;
    assign zero_n = st_q.zero_n;
    assign result_valid = (st_q.fsm == FSM_NORMAL);
    assign bcd_out = st_q.bcd_out;
    assign bcd_oe = st_q.bcd_oe;
    assign digit_strobe = st_q.strobe;
    assign segment_enable = st_q.seg_en;
    assign zero_blank_enable = st_q.lzb_en;

    // ****************************************
    // Assertions
    // ****************************************
    logic [WATCH_W-1:0] pass_cyc_q;
    logic [WATCH_W-1:0] rel_cyc_q;
    // Cycle counters for pass length and time after release
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pass_cyc_q <= '0;
            rel_cyc_q <= '0;
        end else begin
            pass_cyc_q <= (st_q.fsm == FSM_LOAD && !(osc_tick && st_q.phase == PHASE_LSD)) ?
                          pass_cyc_q + WATCH_W'(1) : '0;
            rel_cyc_q <= (st_q.fsm == FSM_LOAD && cnt_lvl != LVL_HIGH && cmp_lvl != LVL_HIGH) ?
                         rel_cyc_q + WATCH_W'(1) : '0;
        end
    end

    sequence s_idle_rise;
        st_q.fsm == FSM_NORMAL && (cnt_rise || cmp_rise);
    endsequence
    sequence s_pass_start;
        st_q.fsm == FSM_LOAD && st_q.phase == PHASE_MSD && st_q.osc_cnt == '0;
    endsequence

    property p_drive_idle;
        @(posedge core_clk) disable iff (!arst_n)
        (st_q.fsm == FSM_NORMAL && cnt_lvl == LVL_OPEN && cmp_lvl == LVL_OPEN && !cnt_rise && !cmp_rise)
        |=> bcd_oe && bcd_out == $past(latch_value[{st_d.phase, 2'b00} +: 4]);
    endproperty
    a_drive_idle: assert property (p_drive_idle) else $error("BCD port not driving latch");

    property p_float_low;
        @(posedge core_clk) disable iff (!arst_n)
        (cnt_lvl == LVL_LOW || cmp_lvl == LVL_LOW) |=> !bcd_oe;
    endproperty
    a_float_low: assert property (p_float_low) else $error("BCD port driven with select low");

    property p_start;
        @(posedge core_clk) disable iff (!arst_n)
        s_idle_rise |=> s_pass_start ##0 (st_q.ld_cnt == $past(cnt_rise)) ##0 (st_q.ld_reg == $past(cmp_rise));
    endproperty
    a_start: assert property (p_start) else $error("Load start not reset to MSD");

    property p_inhibit;
        @(posedge core_clk) disable iff (!arst_n)
        (st_q.fsm == FSM_LOAD && st_q.ld_cnt) |-> count_inhibit && !bcd_oe;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("Counting not inhibited in counter load");

    property p_reg_only;
        @(posedge core_clk) disable iff (!arst_n)
        counter_preset_load |-> $past(st_q.ld_cnt) && $past(st_q.fsm) == FSM_LOAD;
    endproperty
    a_reg_only: assert property (p_reg_only) else $error("Counter preset outside counter load");

    property p_display_off;
        @(posedge core_clk) disable iff (!arst_n)
        (cmp_lvl == LVL_LOW)[*2] |-> digit_strobe == 4'h0 && !segment_enable && st_q.osc_cnt == '0;
    endproperty
    a_display_off: assert property (p_display_off) else $error("Drivers or oscillator active in display off");

    property p_pass_len;
        @(posedge core_clk) disable iff (!arst_n)
        (st_q.fsm == FSM_LOAD && osc_tick && st_q.phase == PHASE_LSD)
        |-> pass_cyc_q == WATCH_W'(DIGITS * DIGIT_CYCLES_P - 1);
    endproperty
    a_pass_len: assert property (p_pass_len) else $error("Load pass length wrong");

    property p_reset_zero;
        @(posedge core_clk) disable iff (!arst_n)
        (st_q.fsm == FSM_LOAD && osc_tick && st_q.ld_reg && !counter_reset_n)
        |=> st_q.cmp[{$past(st_q.phase), 2'b00} +: 4] == 4'h0;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("Register not zero under counter reset");

    property p_keep_reg;
        @(posedge core_clk) disable iff (!arst_n)
        (st_q.fsm == FSM_NORMAL && !cnt_rise && !cmp_rise) |=> $stable(st_q.cmp);
    endproperty
    a_keep_reg: assert property (p_keep_reg) else $error("Compare register changed outside load");

    property p_load_max;
        @(posedge core_clk) disable iff (!arst_n)
        st_q.fsm == FSM_LOAD |-> rel_cyc_q < WATCH_W'(LOAD_MAX_CYCLES_P) && !result_valid;
    endproperty
    a_load_max: assert property (p_load_max) else $error("Load exceeded its maximum time");

    property p_match;
        @(posedge core_clk) disable iff (!arst_n)
        (st_q.cmp == counter_value)[*2] |-> !match_n;
    endproperty
    a_match: assert property (p_match) else $error("Match flag missing on equal values");

    // Outside a load pass, the external scan node alone steps the digit while attached
    property p_ext_scan;
        @(posedge core_clk) disable iff (!arst_n)
        (st_q.fsm == FSM_NORMAL && st_q.ext_scan && !scan_tick_ext && !cnt_rise && !cmp_rise && cmp_lvl != LVL_LOW)
        |=> $stable(st_q.phase);
    endproperty
    a_ext_scan: assert property (p_ext_scan) else $error("Scan phase moved without external tick");
endmodule

/* File: verif/bplc_thumbwheel.sv */
// Thumbwheel switch bank strobed by the digit outputs
`timescale 1ns/10ps
module bplc_thumbwheel (
    // Scan side
    input wire logic [3:0] digit_strobe,
    input wire logic bcd_oe,
    input wire logic [3:0] bcd_out,
    // Switch setting, MSD in top nibble
    input wire logic [15:0] setting,
    // Resolved port level
    output logic [3:0] bcd_in
);
    // Device drive wins; else strobed digit; pull-downs when none selected
    always_comb begin
        bcd_in = 4'h0;
        if (bcd_oe) begin
            bcd_in = bcd_out;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (digit_strobe[i]) begin
                    bcd_in = setting[i*4 +: 4];
                end
            end
        end
    end
endmodule

/* File: verif/bcd_preset_load_control_test.sv */
// Self-checking bench for the BCD preset load control
`timescale 1ns/10ps
module bcd_preset_load_control_test;
    import bplc_pkg::*;
    localparam int D = 4;
    logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic cp_hi, cp_lo, rp_hi, rp_lo, dm_hi, dm_lo, counter_reset_n;
    logic [15:0] counter_value, latch_value, counter_preset_value, setting;
    logic count_inhibit, counter_preset_load, match_n, zero_n, result_valid;
    logic bcd_oe, segment_enable, zero_blank_enable, seen_inh, scan_ext;
    logic [3:0] bcd_in, bcd_out, digit_strobe, prev_strobe;
    int fail_count, checks_done, low_cycles, load_pulses;

    // ****************************************
    // Design, far side and clock
    // ****************************************
    bplc_top #(.DIGIT_CYCLES_P(D), .LOAD_MAX_CYCLES_P(16*D), .CATHODE_VARIANT(1'b0)) bplc_top_inst (
        .core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .counter_preset_select_hi(cp_hi), .counter_preset_select_lo(cp_lo),
        .compare_preset_select_hi(rp_hi), .compare_preset_select_lo(rp_lo),
        .display_mode_select_hi(dm_hi), .display_mode_select_lo(dm_lo),
        .scan_tick_ext(scan_ext), .counter_reset_n, .counter_value, .latch_value, .count_inhibit,
        .counter_preset_value, .counter_preset_load, .match_n, .zero_n, .result_valid,
        .bcd_in, .bcd_out, .bcd_oe, .digit_strobe, .segment_enable, .zero_blank_enable);
    bplc_thumbwheel bplc_thumbwheel_inst (.digit_strobe, .bcd_oe, .bcd_out, .setting, .bcd_in);
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Load pass length, inhibit seen and preset pulses, sampled mid-cycle
    always @(negedge core_clk) begin
        if (result_valid === 1'b0) begin
            low_cycles++;
            if (count_inhibit === 1'b1) seen_inh = 1'b1;
        end
        if (counter_preset_load === 1'b1) load_pulses++;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 20) begin
            fail_count++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Codes per select: 0 open, 1 high, 2 low
    task automatic sel(input int c, input int r, input int m);
        @(posedge core_clk);
        cp_hi <= (c == 1);
        cp_lo <= (c == 2);
        rp_hi <= (r == 1);
        rp_lo <= (r == 2);
        dm_hi <= (m == 1);
        dm_lo <= (m == 2);
        repeat (3) @(negedge core_clk);
    endtask
    task automatic load(input int c, input int r, input logic [15:0] val);
        int n;
        n = 0;
        setting <= val;
        low_cycles = 0;
        seen_inh = 1'b0;
        load_pulses = 0;
        sel(c, r, 0);
        repeat (LOAD_PULSE_CYCLES - 3) @(negedge core_clk);
        sel(0, 0, 0);
        while (result_valid !== 1'b1 && n < 16 * D) begin
            @(negedge core_clk);
            n++;
        end
        // Last digit pulse shows in the first idle cycle
        @(negedge core_clk);
        check("load done", 1'b1, result_valid);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        apb(1'b0, OFS_CTRL, 32'h0);
        check("ctrl reset", 32'h0, rd);
        apb(1'b1, OFS_COMPARE, 32'hffff);
        apb(1'b0, OFS_COMPARE, 32'h0);
        check("compare ro", 32'h0, rd);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped err", 1'b1, err);
        check("unmapped data", 32'h0, rd);
    endtask
    task automatic t_counter();
        load(1, 0, 16'h1234);
        check("preset", 16'h1234, counter_preset_value);
        check("inhibit", 1'b1, seen_inh);
        check("preset pulses", DIGITS, load_pulses);
        check("pass cycles", 4 * D, low_cycles);
        apb(1'b0, OFS_COMPARE, 32'h0);
        check("compare kept", 32'h0, rd);
    endtask
    task automatic t_compare();
        load(0, 1, 16'h5678);
        apb(1'b0, OFS_COMPARE, 32'h0);
        check("compare", 32'h5678, rd);
        check("counter kept", 16'h1234, counter_preset_value);
        check("no preset pulse", 0, load_pulses);
        counter_value <= 16'h5678;
        repeat (3) @(negedge core_clk);
        check("match", 1'b0, match_n);
        @(posedge core_clk);
        counter_value <= 16'h0000;
        repeat (3) @(negedge core_clk);
        check("nomatch", 1'b1, match_n);
        check("zero", 1'b0, zero_n);
    endtask
    task automatic t_both();
        load(1, 1, 16'h9876);
        check("both cnt", 16'h9876, counter_preset_value);
        apb(1'b0, OFS_COMPARE, 32'h0);
        check("both cmp", 32'h9876, rd);
    endtask
    task automatic t_modes();
        latch_value <= 16'h4321;
        sel(0, 0, 0);
        check("oe open", 1'b1, bcd_oe);
        for (int k = 0; k < 12; k++) begin
            prev_strobe = digit_strobe;
            @(negedge core_clk);
            for (int i = 0; i < 4; i++) begin
                if (digit_strobe[i] && prev_strobe === digit_strobe) check("bcd out", i + 1, bcd_out);
            end
        end
        sel(2, 0, 0);
        check("oe cnt low", 1'b0, bcd_oe);
        check("cnt low kept", 16'h9876, counter_preset_value);
        sel(0, 2, 0);
        check("oe cmp low", 1'b0, bcd_oe);
        check("strobe off", 4'h0, digit_strobe);
        check("seg off", 1'b0, segment_enable);
        @(posedge core_clk);
        counter_value <= 16'h9876;
        repeat (3) @(negedge core_clk);
        check("match disp off", 1'b0, match_n);
        sel(0, 0, 1);
        check("seg disp high", 1'b0, segment_enable);
        apb(1'b0, OFS_STATUS, 32'h0);
        check("status", (32'h1 << ST_DISP_LVL_LSB) | (32'h1 << ST_MATCH_BIT), rd & ~(32'h3 << ST_PHASE_LSB));
        sel(0, 0, 2);
        check("blank disp low", 1'b0, zero_blank_enable);
        sel(0, 0, 0);
        check("seg open", 1'b1, segment_enable);
        check("blank open", 1'b1, zero_blank_enable);
    endtask
    // External scan node, then a select held across a pass end
    task automatic t_scan();
        int n;
        n = 0;
        apb(1'b1, OFS_CTRL, 32'h2);
        @(negedge core_clk);
        prev_strobe = digit_strobe;
        repeat (3 * D) @(negedge core_clk);
        check("ext scan hold", prev_strobe, digit_strobe);
        @(posedge core_clk);
        scan_ext <= 1'b1;
        @(posedge core_clk);
        scan_ext <= 1'b0;
        repeat (2) @(negedge core_clk);
        check("ext scan step", {prev_strobe[0], prev_strobe[3:1]}, digit_strobe);
        @(posedge core_clk);
        setting <= 16'h1111;
        low_cycles = 0;
        sel(1, 0, 0);
        repeat (4 * D) @(posedge core_clk);
        setting <= 16'h2468;
        sel(0, 0, 0);
        while (result_valid !== 1'b1 && n < 16 * D) begin
            @(negedge core_clk);
            n++;
        end
        check("repeat done", 1'b1, result_valid);
        check("repeat preset", 16'h2468, counter_preset_value);
        check("repeat cycles", 8 * D, low_cycles);
        apb(1'b1, OFS_CTRL, 32'h0);
    endtask
    task automatic t_reset();
        // Match feeds reset after about 1 us
        check("match before reset", 1'b0, match_n);
        repeat (10) @(posedge core_clk);
        counter_reset_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        counter_reset_n <= 1'b1;
        apb(1'b0, OFS_COMPARE, 32'h0);
        check("reset keeps cmp", 32'h9876, rd);
        counter_reset_n <= 1'b0;
        load(0, 1, 16'h5555);
        @(posedge core_clk);
        counter_reset_n <= 1'b1;
        apb(1'b0, OFS_COMPARE, 32'h0);
        check("load in reset", 32'h0, rd);
        repeat (LOAD_MAX_CYCLES) @(negedge core_clk);
    endtask
    task automatic t_cathode();
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b0, OFS_CTRL, 32'h0);
        check("ctrl write", 32'h1, rd);
        // Switch lines low true for the digits 1234
        load(1, 0, 16'hedcb);
        check("cathode in", 16'h1234, counter_preset_value);
        apb(1'b1, OFS_CTRL, 32'h0);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        fail_count = 0;
        checks_done = 0;
        low_cycles = 0;
        seen_inh = 1'b0;
        {arst_n, psel, penable, pwrite, cp_hi, cp_lo, rp_hi, rp_lo, dm_hi, dm_lo} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        counter_reset_n = 1'b1;
        scan_ext = 1'b0;
        counter_value = 16'h0001;
        latch_value = 16'h0000;
        setting = 16'h0000;
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        t_regs();
        t_counter();
        t_compare();
        t_both();
        t_modes();
        t_scan();
        t_reset();
        t_cathode();
        conclude();
    end
endmodule
